// >>> hw/sdebc_loader.sv
/*
  Strap decoder and start-up configuration loader.
  Latches six four-level straps after reset, derives mode and slave
  address, and in master mode reads swing and gain from an EEPROM.
  Assumes straps arrive already resolved as two-bit level codes, and
  SCL/SDA open-drain with external pull-ups.
*/
`timescale 1ns/1ps
module sdebc_loader (
  input  wire logic                           sys_clk_in,
  input  wire logic                           srst_in,
  input  wire sdebc_pkg::sdebc_level_t        smbus_mode_strap_in,
  input  wire sdebc_pkg::sdebc_level_t        eq_addr_strap_low_in,
  input  wire sdebc_pkg::sdebc_level_t        eq_addr_strap_high_in,
  input  wire sdebc_pkg::sdebc_level_t        receiver_detect_strap_in,
  input  wire sdebc_pkg::sdebc_level_t        output_swing_strap_in,
  input  wire sdebc_pkg::sdebc_level_t        gain_strap_in,
  input  wire logic                           eeprom_load_request_n_in,
  input  wire logic                           scl_in,
  input  wire logic                           sda_in,
  output logic                                scl_out,
  output logic                                scl_oe_out,
  output logic                                sda_out,
  output logic                                sda_oe_out,
  output logic                                load_complete_n_out,
  output logic                                load_error_out,
  output logic                                master_mode_out,
  output logic                                smbus_master_active_out,
  output logic [6:0]                          slave_addr_out,
  output logic [7:0]                          slave_wr_addr_out,
  output logic                                rx_detect_en_out,
  output logic [7:0]                          swing_cfg_out,
  output logic [7:0]                          gain_cfg_out
);
  import sdebc_pkg::*;

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  localparam int unsigned SW = SDEBC_NUM_STRAPS * SDEBC_STRAP_BITS;
  logic [SW-1:0] straps_s;
  logic [2:0]    pins_s;
  sdebc_sync #(.WIDTH(SW)) u_strap_sync (
    .sys_clk_in (sys_clk_in),
    .srst_in    (srst_in),
    .async_in   ({smbus_mode_strap_in, eq_addr_strap_low_in, eq_addr_strap_high_in,
                  receiver_detect_strap_in, output_swing_strap_in, gain_strap_in}),
    .rst_val_in ({SW{1'b0}}),
    .sync_out   (straps_s)
  );
  sdebc_sync #(.WIDTH(3)) u_pin_sync (
    .sys_clk_in (sys_clk_in),
    .srst_in    (srst_in),
    .async_in   ({eeprom_load_request_n_in, scl_in, sda_in}),
    .rst_val_in (3'h7),
    .sync_out   (pins_s)
  );
  wire logic req_n_s = pins_s[2];
  wire logic scl_s   = pins_s[1];
  wire logic sda_s   = pins_s[0];

  // ----------------------------------------------------------------
  // strap latch
  // ----------------------------------------------------------------
  logic [SW-1:0] lat_r,  lat_nxt;
  logic [1:0]    lcnt_r, lcnt_nxt;
  logic          latched_r, latched_nxt;

  always_comb begin
    lat_nxt     = lat_r;
    lcnt_nxt    = lcnt_r;
    latched_nxt = latched_r;
    if (!latched_r) begin
      // wait out the synchroniser depth before capture
      if (lcnt_r == 2'h3) begin
        lat_nxt     = straps_s;
        latched_nxt = 1'b1;
      end else begin
        lcnt_nxt = lcnt_r + 2'h1;
      end
    end
  end
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      lat_r     <= '0;
      lcnt_r    <= 2'h0;
      latched_r <= 1'b0;
    end else begin
      lat_r     <= lat_nxt;
      lcnt_r    <= lcnt_nxt;
      latched_r <= latched_nxt;
    end
  end

  logic [1:0] lv_mode, lv_lo, lv_hi, lv_rxd, lv_swing, lv_gain;
  assign {lv_mode, lv_lo, lv_hi, lv_rxd, lv_swing, lv_gain} = lat_r;

  wire logic       master_sel = latched_r && (lv_mode == SDEBC_L1);
  wire logic [6:0] addr7      = SDEBC_SLAVE_BASE + {3'h0, lv_hi, 2'h0} + {5'h00, lv_lo};

  // ----------------------------------------------------------------
  // SMBus master: random read of two bytes
  // ----------------------------------------------------------------
  sdebc_state_t st_r, st_nxt;
  logic [SDEBC_QTR_W-1:0] qcnt_r, qcnt_nxt;
  logic [1:0] ph_r,   ph_nxt;     // quarter phase within SCL bit
  logic [3:0] bit_r,  bit_nxt;    // 0..7 data, 8 ack
  logic [2:0] byte_r, byte_nxt;   // 0 addr-w, 1 offset, 2 addr-r, 3 data0, 4 data1
  logic [7:0] sh_r,   sh_nxt;
  logic       scl_r,  scl_nxt;
  logic       sda_r,  sda_nxt;    // 1 = release
  logic [7:0] swing_r, swing_nxt;
  logic [7:0] gain_r,  gain_nxt;
  logic       done_n_r, done_n_nxt;
  logic       err_r,    err_nxt;

  function automatic logic [7:0] tx_byte(input logic [2:0] b);
    case (b)
      3'h0:    tx_byte = SDEBC_EEPROM_ADDR;
      3'h1:    tx_byte = SDEBC_SWING_OFS;
      3'h2:    tx_byte = SDEBC_EEPROM_ADDR | 8'h01;
      default: tx_byte = 8'hFF;
    endcase
  endfunction : tx_byte

  wire logic tick = (qcnt_r == SDEBC_QTR_LAST);

  always_comb begin
    st_nxt     = st_r;
    qcnt_nxt   = tick ? '0 : qcnt_r + 1'b1;
    ph_nxt     = ph_r;
    bit_nxt    = bit_r;
    byte_nxt   = byte_r;
    sh_nxt     = sh_r;
    scl_nxt    = scl_r;
    sda_nxt    = sda_r;
    swing_nxt  = swing_r;
    gain_nxt   = gain_r;
    done_n_nxt = done_n_r;
    err_nxt    = err_r;
    case (st_r)
      SDEBC_ST_IDLE: begin
        if (latched_r) begin
          st_nxt = master_sel ? SDEBC_ST_WAIT : SDEBC_ST_DONE;
          if (!master_sel) begin
            swing_nxt = {6'h00, lv_swing};
            gain_nxt  = {6'h00, lv_gain};
          end
        end
      end
      SDEBC_ST_WAIT: begin
        if (!req_n_s) begin
          st_nxt   = SDEBC_ST_START;
          ph_nxt   = 2'h0;
          qcnt_nxt = '0;
          byte_nxt = 3'h0;
        end
      end
      SDEBC_ST_START: begin
        // phases: release SDA, release SCL, SDA low, SCL low; keeps SCL low a half bit on restart
        if (tick) begin
          ph_nxt = ph_r + 2'h1;
          case (ph_r)
            2'h0:    sda_nxt = 1'b1;
            2'h1:    scl_nxt = 1'b1;
            2'h2:    sda_nxt = 1'b0;
            default: begin
              scl_nxt = 1'b0;
              st_nxt  = SDEBC_ST_BYTE;
              bit_nxt = 4'h0;
              sh_nxt  = tx_byte(byte_r);
            end
          endcase
        end
      end
      SDEBC_ST_BYTE: begin
        if (tick) begin
          ph_nxt = ph_r + 2'h1;
          case (ph_r)
            2'h0: begin
              if (bit_r == 4'h8)
                sda_nxt = !(byte_r == 3'h3); // master ack first data, nack last
              else
                sda_nxt = (byte_r >= 3'h3) ? 1'b1 : sh_r[7];
            end
            2'h1: scl_nxt = 1'b1;
            2'h2: begin
              if (scl_s) begin
                if (bit_r == 4'h8) begin
                  if (byte_r < 3'h3 && sda_s) err_nxt = 1'b1; // no acknowledge: stop once SCL is low
                end else begin
                  sh_nxt = {sh_r[6:0], sda_s};
                end
              end else begin
                ph_nxt = ph_r; // clock stretching
              end
            end
            default: begin
              scl_nxt = 1'b0;
              if (bit_r != 4'h8) begin
                bit_nxt = bit_r + 4'h1;
              end else if (err_r) begin
                st_nxt = SDEBC_ST_STOP;
              end else begin
                bit_nxt  = 4'h0;
                if (byte_r == 3'h3) swing_nxt = sh_r;
                if (byte_r == 3'h4) gain_nxt  = sh_r;
                byte_nxt = byte_r + 3'h1;
                sh_nxt   = tx_byte(byte_r + 3'h1);
                if (byte_r == 3'h1) st_nxt = SDEBC_ST_START;
                else if (byte_r == 3'h4) st_nxt = SDEBC_ST_STOP;
              end
            end
          endcase
        end
      end
      SDEBC_ST_STOP: begin
        if (tick) begin
          ph_nxt = ph_r + 2'h1;
          case (ph_r)
            2'h0:    sda_nxt = 1'b0;
            2'h1:    scl_nxt = 1'b1;
            2'h2:    sda_nxt = 1'b1;
            default: st_nxt  = err_r ? SDEBC_ST_FAIL : SDEBC_ST_DONE;
          endcase
        end
      end
      SDEBC_ST_DONE: begin
        done_n_nxt = !master_sel;
      end
      SDEBC_ST_FAIL: begin
        done_n_nxt = 1'b1;
      end
      default: st_nxt = SDEBC_ST_IDLE;
    endcase
  end
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      st_r     <= SDEBC_ST_IDLE;
      qcnt_r   <= '0;
      ph_r     <= 2'h0;
      bit_r    <= 4'h0;
      byte_r   <= 3'h0;
      sh_r     <= 8'h00;
      scl_r    <= 1'b1;
      sda_r    <= 1'b1;
      swing_r  <= SDEBC_SWING_RST;
      gain_r   <= SDEBC_GAIN_RST;
      done_n_r <= 1'b1;
      err_r    <= 1'b0;
    end else begin
      st_r     <= st_nxt;
      qcnt_r   <= qcnt_nxt;
      ph_r     <= ph_nxt;
      bit_r    <= bit_nxt;
      byte_r   <= byte_nxt;
      sh_r     <= sh_nxt;
      scl_r    <= scl_nxt;
      sda_r    <= sda_nxt;
      swing_r  <= swing_nxt;
      gain_r   <= gain_nxt;
      done_n_r <= done_n_nxt;
      err_r    <= err_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  wire logic active = (st_r == SDEBC_ST_START) || (st_r == SDEBC_ST_BYTE) || (st_r == SDEBC_ST_STOP);

  assign scl_out                 = 1'b0;
  assign sda_out                 = 1'b0;
  assign scl_oe_out              = active && !scl_r;
  assign sda_oe_out              = active && !sda_r;
  assign load_complete_n_out     = done_n_r;
  assign load_error_out          = err_r;
  assign master_mode_out         = master_sel;
  assign smbus_master_active_out = active;
  assign slave_addr_out          = addr7;
  assign slave_wr_addr_out       = {addr7, 1'b0};
  assign rx_detect_en_out        = latched_r && (lv_rxd == SDEBC_L2);
  assign swing_cfg_out           = swing_r;
  assign gain_cfg_out            = gain_r;

endmodule : sdebc_loader

// >>> hw/sdebc_sync.sv
/*
  Two-flip-flop synchroniser for a WIDTH-bit asynchronous input.
  Assumes the input is unrelated to sys_clk_in.
*/
`timescale 1ns/1ps
module sdebc_sync #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             sys_clk_in,
  input  wire logic             srst_in,
  input  wire logic [WIDTH-1:0] async_in,
  input  wire logic [WIDTH-1:0] rst_val_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] meta_nxt;
  logic [WIDTH-1:0] sync_r;
  logic [WIDTH-1:0] sync_nxt;

  always_comb begin
    meta_nxt = async_in;
    sync_nxt = meta_r;
  end

  always_ff @(posedge sys_clk_in) begin
    meta_r <= meta_nxt;
    sync_r <= sync_nxt;
  end

  assign sync_out = srst_in ? rst_val_in : sync_r;

endmodule : sdebc_sync

// >>> inc/sdebc_pkg.sv
/*
  Package for the strap decoder and start-up configuration loader:
  strap levels, address arithmetic, SMBus master timing and states.
  Assumes a 200 MHz system clock.
*/
package sdebc_pkg;

  // ----------------------------------------------------------------
  // strap levels
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SDEBC_L0 = 2'h0,
    SDEBC_L1 = 2'h1,
    SDEBC_L2 = 2'h2,
    SDEBC_L3 = 2'h3
  } sdebc_level_t;

  localparam int unsigned SDEBC_NUM_STRAPS = 6;
  localparam int unsigned SDEBC_STRAP_BITS = 2;

  // ----------------------------------------------------------------
  // addresses
  // ----------------------------------------------------------------
  localparam logic [6:0] SDEBC_SLAVE_BASE  = 7'h18;
  localparam logic [7:0] SDEBC_EEPROM_ADDR = 8'hA0;
  localparam logic [7:0] SDEBC_SWING_OFS   = 8'h00;
  localparam logic [7:0] SDEBC_GAIN_OFS    = 8'h01;
  localparam logic [7:0] SDEBC_SWING_RST   = 8'h00;
  localparam logic [7:0] SDEBC_GAIN_RST    = 8'h00;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned SDEBC_CLK_MHZ     = 200;
  localparam int unsigned SDEBC_SCL_KHZ     = 400;
  // quarter period of SCL in system cycles, rounded up so the bus is never fast
  localparam int unsigned SDEBC_QTR_CYCLES  =
    (SDEBC_CLK_MHZ * 1000 + 4 * SDEBC_SCL_KHZ - 1) / (4 * SDEBC_SCL_KHZ);
  localparam int unsigned SDEBC_QTR_W       = 8;
  localparam logic [SDEBC_QTR_W-1:0] SDEBC_QTR_LAST = SDEBC_QTR_W'(SDEBC_QTR_CYCLES - 1);

  // ----------------------------------------------------------------
  // loader states
  // ----------------------------------------------------------------
  typedef enum logic [6:0] {
    SDEBC_ST_IDLE  = 7'h01,
    SDEBC_ST_WAIT  = 7'h02,
    SDEBC_ST_START = 7'h04,
    SDEBC_ST_BYTE  = 7'h08,
    SDEBC_ST_STOP  = 7'h10,
    SDEBC_ST_DONE  = 7'h20,
    SDEBC_ST_FAIL  = 7'h40
  } sdebc_state_t;

endpackage : sdebc_pkg

// >>> testbench/sdebc_eeprom_model.sv
/*
  Behavioural serial EEPROM, 256 bytes, random read only.
  Assumes pulled-up lines; it never stretches SCL.
*/
`timescale 1ns/1ps
module sdebc_eeprom_model
  import sdebc_pkg::*;
(
  input  wire logic scl_in,
  input  wire logic sda_in,
  input  wire logic present_in,
  output logic      sda_oe_out
);
  logic [7:0] mem [0:255];
  logic [7:0] sh, tx, ptr;
  logic [7:0] seen [$];
  int         bitn, st;
  logic       rd;
  initial begin
    sda_oe_out = 1'b0;
    {bitn, st, rd, ptr, tx, sh} = {32'd8, 32'd3, 25'h0};
    foreach (mem[i]) mem[i] = 8'h00;
    mem[8'h00] = 8'h5A;
    mem[8'h01] = 8'hC3;
  end
  // start and stop
  always @(negedge sda_in) if (scl_in === 1'b1) {bitn, st, rd} = {32'd8, 32'd0, 1'b0};
  always @(posedge sda_in) if (scl_in === 1'b1) {st, rd, sda_oe_out} = {32'd3, 2'b00};
  always @(posedge scl_in) begin
    if (bitn < 8) sh = {sh[6:0], sda_in};
    else if (rd && !sda_oe_out && sda_in) st = 3;
    else if (rd && !sda_oe_out) begin
      ptr = ptr + 8'h01;
      tx = mem[ptr];
    end
  end
  always @(negedge scl_in) begin
    bitn = (bitn == 8) ? 0 : bitn + 1;
    sda_oe_out = 1'b0;
    if (bitn < 8 && rd && st != 3) sda_oe_out = !tx[7 - bitn];
    else if (bitn == 8 && !rd && st != 3) begin
      seen.push_back(sh);
      if (st == 0 && sh[7:1] == SDEBC_EEPROM_ADDR[7:1] && present_in) begin
        {sda_oe_out, rd, st} = {1'b1, sh[0], 32'd1};
        tx = mem[ptr];
      end else if (st == 0) st = 3;
      else begin
        if (st == 1) ptr = sh;
        {sda_oe_out, st} = {1'b1, 32'd2};
      end
    end
  end
endmodule : sdebc_eeprom_model

// >>> testbench/sdebc_loader_monitor.sv
/*
  Port checker for sdebc_loader.
  Assumes one clock domain and the bind after the module.
*/
`timescale 1ns/1ps
module sdebc_loader_monitor (
  input wire logic       sys_clk_in,
  input wire logic       srst_in,
  input wire logic       eeprom_load_request_n_in,
  input wire logic       scl_out,
  input wire logic       scl_oe_out,
  input wire logic       sda_out,
  input wire logic       sda_oe_out,
  input wire logic       load_complete_n_out,
  input wire logic       load_error_out,
  input wire logic       master_mode_out,
  input wire logic       smbus_master_active_out,
  input wire logic [6:0] slave_addr_out,
  input wire logic [7:0] slave_wr_addr_out,
  input wire logic       rx_detect_en_out
);
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  logic [3:0] settle_r;
  logic [8:0] run_r;
  logic       req_seen_r;
  always_ff @(posedge sys_clk_in) begin
    settle_r <= srst_in ? 4'h0 : settle_r + {3'h0, settle_r != 4'hF};
    run_r <= ($changed(scl_oe_out) || srst_in) ? 9'h001 : run_r + {8'h00, run_r != 9'h1FF};
    req_seen_r <= !srst_in && (req_seen_r || !eeprom_load_request_n_in);
  end
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (srst_in);
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  wr_addr_a: assert property (slave_wr_addr_out == {slave_addr_out, 1'b0})
    else $error("write address wrong");
  held_cfg_a: assert property (settle_r == 4'hF |-> $stable(slave_addr_out) && $stable(master_mode_out)
    && $stable(rx_detect_en_out)) else $error("latched config moved");
  reset_val_a: assert property (disable iff (1'b0) srst_in |=> slave_addr_out == 7'h18 && !master_mode_out
    && !rx_detect_en_out && load_complete_n_out && !load_error_out) else $error("reset value wrong");
  slave_quiet_a: assert property (!master_mode_out |-> load_complete_n_out && !smbus_master_active_out
    && !scl_oe_out && !sda_oe_out) else $error("slave mode drove bus");
  wait_req_a: assert property (smbus_master_active_out |-> req_seen_r)
    else $error("bus used before request");
  done_release_a: assert property (!load_complete_n_out |-> !smbus_master_active_out && !scl_oe_out
    && !sda_oe_out && !load_error_out) else $error("bus held after done");
  open_drain_a: assert property (scl_out == 1'b0 && sda_out == 1'b0)
    else $error("line driven high");
  scl_low_a: assert property ($fell(scl_oe_out) |-> run_r >= 9'h0F0)
    else $error("scl low too short");
  scl_high_a: assert property ($rose(scl_oe_out) |-> run_r >= 9'h0F0)
    else $error("scl high too short");
  done_c: cover property ($fell(load_complete_n_out));
  error_c: cover property ($rose(load_error_out));
  active_c: cover property ($rose(smbus_master_active_out));
endmodule : sdebc_loader_monitor

bind sdebc_loader sdebc_loader_monitor i_mon (.sys_clk_in(sys_clk_in), .srst_in(srst_in),
  .eeprom_load_request_n_in(eeprom_load_request_n_in), .scl_out(scl_out), .scl_oe_out(scl_oe_out),
  .sda_out(sda_out), .sda_oe_out(sda_oe_out), .load_complete_n_out(load_complete_n_out),
  .load_error_out(load_error_out), .master_mode_out(master_mode_out),
  .smbus_master_active_out(smbus_master_active_out), .slave_addr_out(slave_addr_out),
  .slave_wr_addr_out(slave_wr_addr_out), .rx_detect_en_out(rx_detect_en_out));

// >>> testbench/strap_decode_eeprom_boot_cfg_tb.sv
/*
  Bench for sdebc_loader: strap table, master load, absent EEPROM.
  Assumes sdebc_eeprom_model on pulled-up open-drain lines.
*/
`timescale 1ns/1ps
module strap_decode_eeprom_boot_cfg_tb;
  import sdebc_pkg::*;
  logic         sys_clk_in = 1'b0;
  logic         srst_in = 1'b1;
  logic         req_n = 1'b1;
  logic         present = 1'b1;
  sdebc_level_t s_mode = SDEBC_L0, s_lo = SDEBC_L0, s_hi = SDEBC_L0, s_rx = SDEBC_L0, s_sw = SDEBC_L0;
  sdebc_level_t s_gn = SDEBC_L0;
  logic         scl_oe, sda_oe, mdl_oe, done_n, err, master, active, rx_en;
  logic [6:0]   addr;
  logic [7:0]   wr_addr, swing, gain;
  logic [7:0]   exp_bytes [3] = '{8'hA0, 8'h00, 8'hA1};
  int           n_errors = 0;
  int           comparisons = 0;
  wire logic    scl = ~scl_oe;
  wire logic    sda = ~(sda_oe | mdl_oe);
  always #2.5 sys_clk_in = ~sys_clk_in;
  sdebc_loader i_dut (.sys_clk_in(sys_clk_in), .srst_in(srst_in), .smbus_mode_strap_in(s_mode),
    .eq_addr_strap_low_in(s_lo), .eq_addr_strap_high_in(s_hi), .receiver_detect_strap_in(s_rx),
    .output_swing_strap_in(s_sw), .gain_strap_in(s_gn), .eeprom_load_request_n_in(req_n), .scl_in(scl),
    .sda_in(sda), .scl_out(), .scl_oe_out(scl_oe), .sda_out(), .sda_oe_out(sda_oe), .load_complete_n_out(done_n),
    .load_error_out(err), .master_mode_out(master), .smbus_master_active_out(active), .slave_addr_out(addr),
    .slave_wr_addr_out(wr_addr), .rx_detect_en_out(rx_en), .swing_cfg_out(swing), .gain_cfg_out(gain));
  sdebc_eeprom_model i_eeprom (.scl_in(scl), .sda_in(sda), .present_in(present), .sda_oe_out(mdl_oe));
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h, seen %h", name, exp, seen);
    end
  endtask : check
  task automatic finish_test();
    $display("errors %0d, comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : finish_test
  task automatic boot(input sdebc_level_t m, lo, hi, rx);
    @(negedge sys_clk_in);
    srst_in = 1'b1;
    req_n = 1'b1;
    s_mode = m;
    s_lo = lo;
    s_hi = hi;
    s_rx = rx;
    s_sw = hi;
    s_gn = lo;
    repeat (20) @(negedge sys_clk_in);
    srst_in = 1'b0;
    repeat (12) @(negedge sys_clk_in);
    i_eeprom.seen.delete();
  endtask : boot
  task automatic wait_for(input logic want_err);
    for (int n = 0; n < 60000; n++) begin
      if ((want_err ? err : !done_n) === 1'b1) break;
      @(negedge sys_clk_in);
    end
  endtask : wait_for
  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    for (int i = 0; i < 16; i++) begin
      boot((i % 4 == 1) ? SDEBC_L3 : sdebc_level_t'(2'(i)), sdebc_level_t'(2'(i)), sdebc_level_t'(2'(i >> 2)),
           sdebc_level_t'(2'(i)));
      req_n = 1'b0;
      s_mode = SDEBC_L1;
      s_lo = SDEBC_L3;
      repeat (40) @(negedge sys_clk_in);
      check("slave_addr", {1'b0, addr}, 8'h18 + 8'(i));
      check("write_addr", wr_addr, (8'h18 + 8'(i)) << 1);
      check("master", {7'h00, master}, 8'h00);
      check("rx_detect", {7'h00, rx_en}, {7'h00, i % 4 == 2});
      check("swing", swing, 8'(i >> 2));
      check("gain", gain, 8'(i % 4));
      check("done_n", {7'h00, done_n}, 8'h01);
    end
    boot(SDEBC_L1, SDEBC_L2, SDEBC_L1, SDEBC_L2);
    repeat (400) @(negedge sys_clk_in);
    check("idle_active", {7'h00, active}, 8'h00);
    req_n = 1'b0;
    wait_for(1'b0);
    check("done_n", {7'h00, done_n}, 8'h00);
    check("swing", swing, 8'h5A);
    check("gain", gain, 8'hC3);
    check("error", {7'h00, err}, 8'h00);
    check("master", {7'h00, master}, 8'h01);
    check("rx_detect", {7'h00, rx_en}, 8'h01);
    check("slave_addr", {1'b0, addr}, 8'h1E);
    check("scl_free", {7'h00, scl}, 8'h01);
    check("bytes_sent", 8'(i_eeprom.seen.size()), 8'h03);
    foreach (exp_bytes[k]) check("bus_byte", i_eeprom.seen[k], exp_bytes[k]);
    present = 1'b0;
    boot(SDEBC_L1, SDEBC_L2, SDEBC_L1, SDEBC_L2);
    req_n = 1'b0;
    wait_for(1'b1);
    repeat (600) @(negedge sys_clk_in);
    check("error", {7'h00, err}, 8'h01);
    check("done_n", {7'h00, done_n}, 8'h01);
    check("swing", swing, 8'h00);
    check("nack_byte", i_eeprom.seen[0], 8'hA0);
    finish_test();
  end
  initial begin
    repeat (50000) @(posedge sys_clk_in);
    n_errors++;
    finish_test();
  end
endmodule : strap_decode_eeprom_boot_cfg_tb
